// >>> shared/fscr_regs.svh
// register offsets, field positions, reset values for the fifo and synth counter bank
`ifndef FSCR_REGS_SVH
`define FSCR_REGS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FSCR_IDX_GCON   5'h00
`define FSCR_IDX_FIFOC  5'h05
`define FSCR_IDX_R1     5'h06
`define FSCR_IDX_P1     5'h07
`define FSCR_IDX_S1     5'h08
`define FSCR_IDX_R2     5'h09
`define FSCR_IDX_STAT   5'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define FSCR_DEPTH_HI   7
`define FSCR_DEPTH_LO   6
`define FSCR_THR_HI     5
`define FSCR_THR_LO     0
`define FSCR_SEL_BIT    0

// ----------------------------------------
// reset values
// ----------------------------------------
`define FSCR_RST_FIFOC  8'h0F
`define FSCR_RST_R1     8'h77
`define FSCR_RST_P1     8'h64
`define FSCR_RST_S1     8'h32
`define FSCR_RST_R2     8'h74
`define FSCR_RST_GCON   8'h00

// ----------------------------------------
// depth sizes in bytes
// ----------------------------------------
`define FSCR_DEPTH_64   7'h40
`define FSCR_DEPTH_48   7'h30
`define FSCR_DEPTH_32   7'h20

`endif

// >>> shared/fscr_pkg.sv
// types and shared decode for the fifo and synth counter bank
`include "fscr_regs.svh"
package fscr_pkg;

  // ----------------------------------------
  // operating mode of the transceiver
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSCR_MODE_STBY = 2'h0,  // stand-by
    FSCR_MODE_RX   = 2'h1,  // receive
    FSCR_MODE_TX   = 2'h2   // transmit
  } fscr_mode_t;

  // ----------------------------------------
  // bus handshake states, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSCR_BUS_IDLE = 2'b01,  // waiting for a request
    FSCR_BUS_ACK  = 2'b10   // waitrequest low this cycle
  } fscr_bus_state_t;

  // depth code to size in bytes
  function automatic logic [6:0] fscr_depth_bytes(input logic [1:0] code);
    case (code)
      2'h3:    fscr_depth_bytes = `FSCR_DEPTH_64;
      2'h2:    fscr_depth_bytes = `FSCR_DEPTH_48;
      default: fscr_depth_bytes = `FSCR_DEPTH_32;  // 01, and 00 as smallest
    endcase
  endfunction

endpackage

// >>> shared/fscr_reg_if.sv
// internal register access carrier between bus slave and register bank
interface fscr_reg_if;
  logic [4:0] index;    // register index
  logic [7:0] wdata;    // write data, low byte
  logic       wr_pulse; // one-cycle write commit
  logic [7:0] rdata;    // read data of indexed register
  logic       hit;      // index is mapped

  // ----------------------------------------
  // bus slave side
  // ----------------------------------------
  modport slave (output index, output wdata, output wr_pulse, input rdata, input hit);

  // ----------------------------------------
  // register bank side
  // ----------------------------------------
  modport bank (input index, input wdata, input wr_pulse, output rdata, output hit);
endinterface

// >>> src/fscr_avalon_slave.sv
// avalon-mm slave with waitrequest, one wait cycle per access
module fscr_avalon_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm
  input  wire logic [6:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // register bank
  fscr_reg_if.slave        rif
);

  fscr_pkg::fscr_bus_state_t state_reg;  // handshake state

  // decode word index and low byte
  assign rif.index    = address[6:2];
  assign rif.wdata    = writedata[7:0];
  // write lands only in the ack cycle, low lane enabled
  assign rif.wr_pulse = write & (state_reg == fscr_pkg::FSCR_BUS_ACK) & byteenable[0];

  // ----------------------------------------
  // handshake: one wait cycle, then ack cycle
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= fscr_pkg::FSCR_BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (state_reg)
        fscr_pkg::FSCR_BUS_IDLE: begin
          if (read | write) begin
            state_reg   <= fscr_pkg::FSCR_BUS_ACK;
            waitrequest <= 1'b0;
          end
        end
        fscr_pkg::FSCR_BUS_ACK: begin
          // master releases at this edge
          state_reg   <= fscr_pkg::FSCR_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state_reg   <= fscr_pkg::FSCR_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data captured as ack begins; unmapped reads zero
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if ((state_reg == fscr_pkg::FSCR_BUS_IDLE) && read) begin
      readdata <= {24'h00_0000, (rif.hit ? rif.rdata : 8'h00)};
    end
  end

endmodule

// >>> src/fscr_threshold.sv
// fifo threshold interrupt source, behaviour set by operating mode
module fscr_threshold (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // configuration and state
  input  wire logic [5:0] threshold,
  input  wire logic [6:0] fill_level,
  input  wire logic [1:0] mode,
  // interrupt source
  output logic            source
);

  logic at_or_above;  // level reached threshold
  logic below;        // level not above threshold

  assign at_or_above = fill_level >= {1'b0, threshold};
  assign below       = fill_level <= {1'b0, threshold};

  // ----------------------------------------
  // tx asks for data while level is low; rx and stand-by flag data waiting
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      source <= 1'b0;
    end else begin
      case (fscr_pkg::fscr_mode_t'(mode))
        fscr_pkg::FSCR_MODE_TX:   source <= below;
        fscr_pkg::FSCR_MODE_RX:   source <= at_or_above;
        fscr_pkg::FSCR_MODE_STBY: source <= at_or_above;
        default:                  source <= 1'b0;
      endcase
    end
  end

endmodule

// >>> src/fscr_top.sv
// fifo configuration and synthesizer counter register bank
`include "fscr_regs.svh"
module fscr_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,

  // avalon-mm slave
  input  wire logic [6:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,

  // fifo datapath and mode
  input  wire logic [6:0]  fifo_fill_level,
  input  wire logic [1:0]  operating_mode,

  // second-set p and s counters from the rest of the bank
  input  wire logic [7:0]  p_counter_value_two,
  input  wire logic [7:0]  s_counter_value_two,

  // fifo sizing and threshold source
  output logic      [6:0]  fifo_depth_bytes,
  output logic      [5:0]  fifo_threshold,
  output logic             fifo_threshold_source,

  // counters for the synthesizer
  output logic      [7:0]  synth_ref_divider,
  output logic      [7:0]  synth_p_counter,
  output logic      [7:0]  synth_s_counter
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] fifo_configuration_reg;         // depth and threshold
  logic [7:0] synth_ref_divider_set_one_reg;  // first reference divider
  logic [7:0] synth_p_counter_set_one_reg;    // first p counter
  logic [7:0] synth_s_counter_set_one_reg;    // first s counter
  logic [7:0] synth_ref_divider_set_two_reg;  // second reference divider
  logic [7:0] general_config_register_reg;    // holds counter set select

  // ----------------------------------------
  // decoded fields
  // ----------------------------------------
  logic [1:0] fifo_depth_select;     // depth code
  logic [5:0] fifo_level_threshold;  // threshold field
  logic       counter_set_select;    // 0 first set, 1 second set
  logic [7:0] status_byte;           // readable block state

  // register access carrier
  fscr_reg_if rif ();

  assign fifo_depth_select    = fifo_configuration_reg[`FSCR_DEPTH_HI:`FSCR_DEPTH_LO];
  assign fifo_level_threshold = fifo_configuration_reg[`FSCR_THR_HI:`FSCR_THR_LO];
  assign counter_set_select   = general_config_register_reg[`FSCR_SEL_BIT];

  // status: threshold source, selected set, current mode, depth code
  assign status_byte = {2'h0,
                        fifo_threshold_source,
                        counter_set_select,
                        operating_mode,
                        fifo_depth_select};

  // write strobe for one register index
  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = rif.wr_pulse && (rif.index == idx);
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  fscr_avalon_slave u_slave (
    .clk         (clk),
    .reset       (reset),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .rif         (rif.slave)
  );

  // ----------------------------------------
  // fifo configuration register
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_configuration_reg <= `FSCR_RST_FIFOC;
    end else if (wr_hit(`FSCR_IDX_FIFOC)) begin
      fifo_configuration_reg <= rif.wdata;
    end
  end

  // ----------------------------------------
  // first counter set
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_ref_divider_set_one_reg <= `FSCR_RST_R1;
    end else if (wr_hit(`FSCR_IDX_R1)) begin
      synth_ref_divider_set_one_reg <= rif.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_p_counter_set_one_reg <= `FSCR_RST_P1;
    end else if (wr_hit(`FSCR_IDX_P1)) begin
      synth_p_counter_set_one_reg <= rif.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_s_counter_set_one_reg <= `FSCR_RST_S1;
    end else if (wr_hit(`FSCR_IDX_S1)) begin
      synth_s_counter_set_one_reg <= rif.wdata;
    end
  end

  // ----------------------------------------
  // second reference divider
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_ref_divider_set_two_reg <= `FSCR_RST_R2;
    end else if (wr_hit(`FSCR_IDX_R2)) begin
      synth_ref_divider_set_two_reg <= rif.wdata;
    end
  end

  // ----------------------------------------
  // general configuration: counter set select
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      general_config_register_reg <= `FSCR_RST_GCON;
    end else if (wr_hit(`FSCR_IDX_GCON)) begin
      general_config_register_reg <= rif.wdata;
    end
  end

  // ----------------------------------------
  // read mux and map decode
  // ----------------------------------------
  always_comb begin
    rif.hit   = 1'b1;
    rif.rdata = 8'h00;
    case (rif.index)
      `FSCR_IDX_GCON:  rif.rdata = general_config_register_reg;
      `FSCR_IDX_FIFOC: rif.rdata = fifo_configuration_reg;
      `FSCR_IDX_R1:    rif.rdata = synth_ref_divider_set_one_reg;
      `FSCR_IDX_P1:    rif.rdata = synth_p_counter_set_one_reg;
      `FSCR_IDX_S1:    rif.rdata = synth_s_counter_set_one_reg;
      `FSCR_IDX_R2:    rif.rdata = synth_ref_divider_set_two_reg;
      `FSCR_IDX_STAT:  rif.rdata = status_byte;
      default:         rif.hit   = 1'b0;  // unmapped reads zero
    endcase
  end

  // ----------------------------------------
  // fifo depth from depth code; 00 maps to smallest
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_depth_bytes <= `FSCR_DEPTH_32;
    end else begin
      fifo_depth_bytes <= fscr_pkg::fscr_depth_bytes(fifo_depth_select);
    end
  end

  // threshold field copied out for the fifo datapath
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_threshold <= 6'h00;
    end else begin
      fifo_threshold <= fifo_level_threshold;
    end
  end

  // ----------------------------------------
  // threshold interrupt source
  // ----------------------------------------
  fscr_threshold u_thr (
    .clk        (clk),
    .reset      (reset),
    .threshold  (fifo_level_threshold),
    .fill_level (fifo_fill_level),
    .mode       (operating_mode),
    .source     (fifo_threshold_source)
  );

  // ----------------------------------------
  // counter set selection for carrier generation
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      synth_ref_divider <= `FSCR_RST_R1;
      synth_p_counter   <= `FSCR_RST_P1;
      synth_s_counter   <= `FSCR_RST_S1;
    end else if (counter_set_select) begin
      // second set; p and s come from outside this slice
      synth_ref_divider <= synth_ref_divider_set_two_reg;
      synth_p_counter   <= p_counter_value_two;
      synth_s_counter   <= s_counter_value_two;
    end else begin
      // first set
      synth_ref_divider <= synth_ref_divider_set_one_reg;
      synth_p_counter   <= synth_p_counter_set_one_reg;
      synth_s_counter   <= synth_s_counter_set_one_reg;
    end
  end

endmodule

// >>> tb/fscr_far_model.sv
// model of the device around the bank: fifo level, operating mode, second-set p and s
module fscr_far_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // requested state from the bench
  input  wire logic [6:0] set_fill,
  input  wire logic [1:0] set_mode,
  // outputs toward the bank
  output logic      [6:0] fill_level,
  output logic      [1:0] mode,
  output logic      [7:0] p_two,
  output logic      [7:0] s_two
);
  timeunit 1ns;
  timeprecision 1ns;

  // fifo and mode settle one edge after the bench asks, as a real datapath would
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fill_level <= 7'h00;
      mode       <= 2'h0;
      p_two      <= 8'h62;  // second-set p at reset
      s_two      <= 8'h32;  // second-set s at reset
    end else begin
      fill_level <= set_fill;
      mode       <= set_mode;
    end
  end
endmodule

// >>> tb/fscr_top_asserts.sv
// concurrent checks on the ports of the fifo and synth counter bank
module fscr_top_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // avalon-mm
  input wire logic [6:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // side inputs
  input wire logic [6:0]  fifo_fill_level,
  input wire logic [1:0]  operating_mode,
  input wire logic [7:0]  p_counter_value_two,
  input wire logic [7:0]  s_counter_value_two,
  // derived outputs
  input wire logic [6:0]  fifo_depth_bytes,
  input wire logic [5:0]  fifo_threshold,
  input wire logic        fifo_threshold_source,
  input wire logic [7:0]  synth_ref_divider,
  input wire logic [7:0]  synth_p_counter,
  input wire logic [7:0]  synth_s_counter
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // accepted writes to fifo config and general config
  logic wr_fifo;
  logic wr_gcon;
  assign wr_fifo = !waitrequest && write && byteenable[0] && address[6:2] == 5'h05;
  assign wr_gcon = !waitrequest && write && byteenable[0] && address[6:2] == 5'h00;

  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_req_answer: assert property ($rose(read || write) |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  chk_depth_code: assert property (wr_fifo |-> ##2 fifo_depth_bytes == ($past(writedata[7], 2) ?
    ($past(writedata[6], 2) ? 7'h40 : 7'h30) : 7'h20)) else $error("fifo depth does not follow code");
  chk_thr_field: assert property (wr_fifo |-> ##2 fifo_threshold == $past(writedata[5:0], 2))
    else $error("threshold does not follow field");
  chk_sel_two: assert property (wr_gcon && writedata[0] |-> ##2 synth_p_counter == p_counter_value_two
    && synth_s_counter == s_counter_value_two) else $error("second set not selected");
  chk_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("readdata upper bits not zero");
  chk_unmapped_zero: assert property (!waitrequest && read && !(address[6:2] inside {5'h00, 5'h05, 5'h06,
    5'h07, 5'h08, 5'h09, 5'h10}) |-> readdata == 32'h00000000) else $error("unmapped read not zero");
  chk_src_tx: assert property (!$past(reset) && $past(operating_mode) == 2'h2 |->
    fifo_threshold_source == ($past(fifo_fill_level) <= {1'b0, fifo_threshold})) else $error("tx source wrong");
  chk_src_rx: assert property (!$past(reset) && $past(operating_mode) < 2'h2 |->
    fifo_threshold_source == ($past(fifo_fill_level) >= {1'b0, fifo_threshold})) else $error("rx source wrong");
endmodule

bind fscr_top fscr_top_asserts u_chk (.clk(clk), .reset(reset), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .fifo_fill_level(fifo_fill_level), .operating_mode(operating_mode),
  .p_counter_value_two(p_counter_value_two), .s_counter_value_two(s_counter_value_two),
  .fifo_depth_bytes(fifo_depth_bytes), .fifo_threshold(fifo_threshold),
  .fifo_threshold_source(fifo_threshold_source), .synth_ref_divider(synth_ref_divider),
  .synth_p_counter(synth_p_counter), .synth_s_counter(synth_s_counter));

// >>> tb/tb.sv
// self-checking bench for the fifo and synth counter bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, reset, read, write, waitrequest, src;
  logic [6:0]  address, set_fill, fill, depth;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  logic [1:0]  set_mode, mode;
  logic [7:0]  p_two, s_two, syn_r, syn_p, syn_s;
  logic [5:0]  thr;
  int          miscompares, check_count;
  logic [4:0]  idx_tab [6] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09};  // mapped indices
  logic [7:0]  rst_tab [6] = '{8'h00, 8'h0F, 8'h77, 8'h64, 8'h32, 8'h74};  // their reset values

  fscr_top dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fifo_fill_level(fill), .operating_mode(mode), .p_counter_value_two(p_two), .s_counter_value_two(s_two),
    .fifo_depth_bytes(depth), .fifo_threshold(thr), .fifo_threshold_source(src),
    .synth_ref_divider(syn_r), .synth_p_counter(syn_p), .synth_s_counter(syn_s));
  fscr_far_model far (.clk(clk), .reset(reset), .set_fill(set_fill), .set_mode(set_mode),
    .fill_level(fill), .mode(mode), .p_two(p_two), .s_two(s_two));

  // 20 MHz clock
  always #25 clk = ~clk;

  // ----------------------------------------
  // report, compare and bus tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one access: hold until waitrequest is seen low, take readdata there, then release
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    address    <= {idx, 2'b00};
    writedata  <= {24'h000000, d};
    byteenable <= be;
    write      <= wr;
    read       <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  // write then let the derived outputs land
  task automatic wr_settle(input logic [4:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
    @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 0;
    reset = 1;
    read = 0;
    write = 0;
    address = 0;
    byteenable = 0;
    writedata = 0;
    set_fill = 0;
    set_mode = 0;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values through the bus and at the outputs
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, idx_tab[i], 8'h00, 4'hF);
      cmp("reset value", rst_tab[i], rd);
    end
    cmp("ref divider", 8'h77, syn_r);
    cmp("p counter", 8'h64, syn_p);
    cmp("s counter", 8'h32, syn_s);
    cmp("fifo depth", 7'h20, depth);
    cmp("fifo threshold", 6'h0F, thr);
    // every depth code with a distinct threshold
    for (int c = 0; c < 4; c++) begin
      wr_settle(5'h05, {c[1:0], 4'hA, c[1:0]});
      cmp("fifo depth", c == 3 ? 7'h40 : (c == 2 ? 7'h30 : 7'h20), depth);
      cmp("fifo threshold", {4'hA, c[1:0]}, thr);
      bus(1'b0, 5'h05, 8'h00, 4'hF);
      cmp("fifo config", {c[1:0], 4'hA, c[1:0]}, rd);
    end
    // threshold source in each mode around threshold 0x10
    wr_settle(5'h05, 8'hD0);
    for (int m = 0; m < 4; m++) begin
      for (int f = 15; f < 18; f++) begin
        set_mode <= m[1:0];
        set_fill <= f[6:0];
        repeat (3) @(posedge clk);
        cmp("threshold source", m == 3 ? 1'b0 : (m == 2 ? (f <= 16) : (f >= 16)), src);
      end
    end
    // counter set select
    wr_settle(5'h00, 8'h01);
    cmp("ref divider", 8'h74, syn_r);
    cmp("p counter", 8'h62, syn_p);
    cmp("s counter", 8'h32, syn_s);
    wr_settle(5'h09, 8'h5A);
    cmp("ref divider", 8'h5A, syn_r);
    wr_settle(5'h06, 8'h12);
    cmp("ref divider", 8'h5A, syn_r);
    wr_settle(5'h00, 8'h00);
    cmp("ref divider", 8'h12, syn_r);
    cmp("p counter", 8'h64, syn_p);
    cmp("s counter", 8'h32, syn_s);
    // refused accesses: byte lane off, unmapped index
    bus(1'b1, 5'h07, 8'hEE, 4'h0);
    bus(1'b0, 5'h07, 8'h00, 4'hF);
    cmp("p counter readback", 8'h64, rd);
    bus(1'b1, 5'h1F, 8'hFF, 4'hF);
    bus(1'b0, 5'h1F, 8'h00, 4'hF);
    cmp("unmapped read", 32'h00000000, rd);
    // status word: source set in receive mode, first set, depth code 11
    set_mode <= 2'h1;
    set_fill <= 7'h11;
    repeat (3) @(posedge clk);
    bus(1'b0, 5'h10, 8'h00, 4'hF);
    cmp("status", 8'h27, rd);
    // reset again in mid-run: first and second ref divider and fifo config back to their reset values
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    cmp("ref divider", 8'h77, syn_r);
    cmp("fifo depth", 7'h20, depth);
    bus(1'b0, 5'h09, 8'h00, 4'hF);
    cmp("second ref divider", 8'h74, rd);
    bus(1'b0, 5'h05, 8'h00, 4'hF);
    cmp("fifo config", 8'h0F, rd);
    cmp("fifo threshold", 6'h0F, thr);
    give_verdict();
  end
endmodule
